// file: rtl/case_sel_pkg.sv
/*
 Constants, field layouts and types shared by the monitoring case selector
 and its field suggestion store. Assumes a 40 MHz aclk and AXI4-Lite access.
*/
// Overview of operation
// RULE_01 - Pairs read as binary, first pair LSB, case=value+1
// RULE_02 - Safety link gives five pairs, thirty-two cases
// RULE_03 - Local static: one, four or eight cases
// RULE_04 - Dynamic local sixteen/thirty-two; link always thirty-two
// RULE_05 - Unmatched input combination forces outputs OFF
// RULE_06 - Object in protective field forces outputs OFF
// RULE_07 - Contour outside tolerance band forces outputs OFF
// RULE_08 - Contour reference and warning field two exclusive
// RULE_09 - No warning field over contour segment sectors
// RULE_10 - Case record: condition, field set, follow-ons, sampling
// RULE_11 - Select by static, speed, or both combined
// RULE_12 - Field set count set by variant alone
// RULE_13 - Repeated contour scans collected for the host
// RULE_14 - Suggested field: contour minus tolerance, else range
// RULE_15 - Controller switches inputs before hazard arises
// RULE_16 - Vertical mounting needs contour reference enabled
// RULE_17 - Non-complementary pair counts as undefined input
`default_nettype none
package case_sel_pkg;
	localparam int AW = 8;
	typedef logic [AW-1:0] addr_t;
	localparam addr_t OFS_CTRL = 8'h00;
	localparam addr_t OFS_STATUS = 8'h04;
	localparam addr_t OFS_IRQ_CLR = 8'h08;
	localparam addr_t OFS_IRQ_EN = 8'h0C;
	localparam addr_t OFS_CASE_IDX = 8'h10;
	localparam addr_t OFS_CASE_DATA = 8'h14;
	localparam addr_t OFS_WARN_MASK = 8'h18;
	localparam addr_t OFS_CONT_MASK = 8'h1C;
	localparam addr_t OFS_ACTIVE = 8'h20;
	localparam addr_t OFS_SUGG_IDX = 8'h24;
	localparam addr_t OFS_SUGG_DATA = 8'h28;
	localparam addr_t OFS_SUGG_CFG = 8'h2C;

	localparam int CTRL_VAR = 0;
	localparam int CTRL_LINK = 2;
	localparam int CTRL_MODE = 3;
	localparam int CTRL_CONT = 5;
	localparam int CTRL_WF2 = 6;
	localparam int CTRL_RUN = 7;
	localparam int CTRL_SUGG = 8;
	localparam int CTRL_SCLR = 9;
	localparam int CTRL_W = 9;
	localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

	typedef enum logic [1:0] {
		VAR_STANDARD = 2'b00,
		VAR_ADVANCED = 2'b01,
		VAR_PROFESSIONAL = 2'b10,
		VAR_EXPERT = 2'b11
	} variant_t;
	typedef enum logic [1:0] {
		SEL_STATIC = 2'b00,
		SEL_SPEED = 2'b01,
		SEL_COMBINED = 2'b10
	} sel_mode_t;
	typedef enum logic [1:0] {
		FOLLOW_NONE = 2'b00,
		FOLLOW_UNIQUE = 2'b01,
		FOLLOW_ALT = 2'b10
	} follow_t;

	localparam int ST_UNDEF = 0;
	localparam int ST_FIELD = 1;
	localparam int ST_CONTOUR = 2;
	localparam int ST_CFG = 3;
	localparam int ST_W = 4;

	localparam int REC_FS = 0;
	localparam int REC_FM = 4;
	localparam int REC_FA = 6;
	localparam int REC_FB = 11;
	localparam int REC_MS = 16;
	localparam int REC_VALID = 20;
	localparam int REC_W = 21;

	localparam int NUM_CASES = 32;
	localparam int CASE_W = 5;
	localparam int LOCAL_PAIRS = 3;
	localparam int LINK_PAIRS = 5;
	localparam logic [2:0] LINK_USED = 3'h5;
	localparam logic [5:0] CAP_LINK = 6'h20;
	localparam logic [5:0] CAP_STATIC [0:3] = '{6'h01, 6'h04, 6'h08, 6'h08};
	localparam logic [5:0] CAP_DYN [0:3] = '{6'h00, 6'h00, 6'h10, 6'h20};
	localparam logic [2:0] PAIRS_USED [0:3] = '{3'h0, 3'h2, 3'h3, 3'h3};
	localparam logic [4:0] FS_COUNT [0:3] = '{5'h01, 5'h04, 5'h08, 5'h10};

	localparam int SEC_N = 16;
	localparam int SEC_W = 4;
	localparam int RANGE_W = 12;
	localparam int SCFG_TOL = 16;
	localparam logic [RANGE_W-1:0] SUGG_MAX_RST = 12'hFFF;
	localparam logic [RANGE_W-1:0] SUGG_TOL_RST = 12'h000;
	localparam logic [RANGE_W-1:0] RANGE_INIT = 12'hFFF;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// file: rtl/field_suggest.sv
/*
 Per-sector minimum of repeated contour scans and the suggested
 protective field derived from it. Samples come from scan logic on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module field_suggest (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic clear, // Restart collection
	input wire logic enable, // Collect samples
	input wire logic meas_valid, // Sample strobe
	input wire logic [case_sel_pkg::SEC_W-1:0] meas_angle, // Sector of sample
	input wire logic [case_sel_pkg::RANGE_W-1:0] meas_range, // Measured range
	input wire logic [case_sel_pkg::RANGE_W-1:0] max_range, // Scanning range limit
	input wire logic [case_sel_pkg::RANGE_W-1:0] tol, // Measuring error tolerance
	input wire logic [case_sel_pkg::SEC_W-1:0] rd_idx, // Sector to read
	output logic [case_sel_pkg::RANGE_W-1:0] rd_range // Suggested field range
);
	import case_sel_pkg::*;

	logic [RANGE_W-1:0] min_q [SEC_N];
	logic [RANGE_W-1:0] raw;

	// Nearest echo over all scans wins, so a passing object shrinks the field [RULE_13]
	for (genvar i = 0; i < SEC_N; i++) begin : g_sec
		always_ff @(posedge aclk) begin
			if (!aresetn || clear) begin
				min_q[i] <= RANGE_INIT;
			end else if (enable && meas_valid && meas_angle == SEC_W'(i)
				&& meas_range < min_q[i]) begin
				min_q[i] <= meas_range;
			end
		end
	end

	assign raw = min_q[rd_idx];
	// Tolerance saturates at zero instead of wrapping [RULE_14]
	assign rd_range = (raw < max_range) ? ((raw > tol) ? raw - tol : '0) : max_range;
endmodule
`default_nettype wire

// file: rtl/case_selector.sv
/*
 Monitoring case selector: decodes control input pairs and speed into the
 active case and drives the safety switching output, with AXI4-Lite registers.
 Assumes scan logic on aclk supplies field, contour and speed information.
*/
`timescale 1ns/1ps
`default_nettype none
module case_selector (
	input wire logic aclk, // 40 MHz clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [case_sel_pkg::AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [case_sel_pkg::AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic [case_sel_pkg::LOCAL_PAIRS-1:0] local_pair_p, // Local pair lines 1
	input wire logic [case_sel_pkg::LOCAL_PAIRS-1:0] local_pair_n, // Local pair lines 2
	input wire logic [case_sel_pkg::LINK_PAIRS-1:0] link_pair_p, // Link pair lines 1
	input wire logic [case_sel_pkg::LINK_PAIRS-1:0] link_pair_n, // Link pair lines 2
	input wire logic field_hit, // Object in active protective field
	input wire logic contour_lost, // Contour outside tolerance band
	input wire logic [case_sel_pkg::CASE_W-1:0] speed_case, // Case index from speed
	input wire logic speed_valid, // Speed information valid
	input wire logic meas_valid, // Contour sample strobe
	input wire logic [case_sel_pkg::SEC_W-1:0] meas_angle, // Contour sample sector
	input wire logic [case_sel_pkg::RANGE_W-1:0] meas_range, // Contour sample range
	output logic safety_switching_output, // High = ON
	output logic [case_sel_pkg::CASE_W-1:0] active_case, // Active case index
	output logic case_undefined, // Input information undefined
	output logic irq // Enabled status pending
);
	import case_sel_pkg::*;
	function automatic logic [5:0] decode_pairs(input logic [4:0] p, input logic [4:0] n,
		input logic [2:0] used);
		logic ok;
		logic [4:0] idx;
		ok = 1'b1;
		idx = '0;
		for (int k = 0; k < 5; k++) begin
			if (3'(k) < used) begin
				if (p[k] == n[k]) begin
					ok = 1'b0; // [RULE_17]
				end
				idx[k] = p[k]; // [RULE_01]
			end
		end
		return {ok, idx};
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction
	// Input synchronisers
	logic [LOCAL_PAIRS-1:0] lp_m_q, lp_s_q, ln_m_q, ln_s_q;
	logic [LINK_PAIRS-1:0] kp_m_q, kp_s_q, kn_m_q, kn_s_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lp_m_q <= '0;
			lp_s_q <= '0;
			ln_m_q <= '0;
			ln_s_q <= '0;
			kp_m_q <= '0;
			kp_s_q <= '0;
			kn_m_q <= '0;
			kn_s_q <= '0;
		end else begin
			lp_m_q <= local_pair_p;
			lp_s_q <= lp_m_q;
			ln_m_q <= local_pair_n;
			ln_s_q <= ln_m_q;
			kp_m_q <= link_pair_p;
			kp_s_q <= kp_m_q;
			kn_m_q <= link_pair_n;
			kn_s_q <= kn_m_q;
		end
	end

	// Registers
	logic [CTRL_W-1:0] ctrl_q;
	logic [ST_W-1:0] status_q, irq_en_q;
	logic [CASE_W-1:0] case_idx_q;
	logic [SEC_N-1:0] warn_mask_q, cont_mask_q;
	logic [SEC_W-1:0] sugg_idx_q;
	logic [RANGE_W-1:0] sugg_max_q, sugg_tol_q;
	logic [REC_W-1:0] case_tab_q [NUM_CASES];
	logic have_case_q;
	wire [1:0] var_sel = ctrl_q[CTRL_VAR +: 2];
	wire link_src = ctrl_q[CTRL_LINK];
	wire [1:0] mode = ctrl_q[CTRL_MODE +: 2];
	wire cont_en = ctrl_q[CTRL_CONT];
	wire run = ctrl_q[CTRL_RUN];
	// Static information: link pairs or the variant's local pairs
	wire [5:0] loc_dec = decode_pairs({2'b00, lp_s_q}, {2'b00, ln_s_q}, PAIRS_USED[var_sel]);
	wire [5:0] link_dec = decode_pairs(kp_s_q, kn_s_q, LINK_USED); // [RULE_02]
	wire [5:0] st_dec = link_src ? link_dec : loc_dec;
	wire st_ok = st_dec[5];
	wire [CASE_W-1:0] st_idx = st_dec[4:0];
	// Combined mode asks static and speed to name the same case [RULE_11]
	wire cand_ok = (mode == SEL_STATIC) ? st_ok :
		(mode == SEL_SPEED) ? speed_valid :
		(mode == SEL_COMBINED) ? (st_ok && speed_valid && st_idx == speed_case) : 1'b0;
	wire [CASE_W-1:0] cand = (mode == SEL_SPEED) ? speed_case : st_idx;
	// Capacity by variant and source [RULE_03] [RULE_04]
	wire [5:0] cap = link_src ? CAP_LINK :
		(mode == SEL_STATIC) ? CAP_STATIC[var_sel] : CAP_DYN[var_sel];
	wire in_cap = {1'b0, cand} < cap;
	wire [REC_W-1:0] cand_rec = case_tab_q[cand];
	wire [REC_W-1:0] cur_rec = case_tab_q[active_case];
	wire [1:0] fm = cur_rec[REC_FM +: 2];
	wire [CASE_W-1:0] fa = cur_rec[REC_FA +: CASE_W];
	wire [CASE_W-1:0] fb = cur_rec[REC_FB +: CASE_W];
	// A case with follow-ons may only hand over to one of them [RULE_10]
	wire follow_ok = !have_case_q || cand == active_case || fm == FOLLOW_NONE
		|| (fm == FOLLOW_UNIQUE && cand == fa)
		|| (fm == FOLLOW_ALT && (cand == fa || cand == fb));
	wire sel_ok = cand_ok && in_cap && cand_rec[REC_VALID] && follow_ok; // [RULE_05]

	// Undefined input, intrusion and contour loss all drop the output
	wire out_on_d = run && sel_ok && !field_hit // [RULE_05] [RULE_06]
		&& !(cont_en && contour_lost); // [RULE_07]

	// AXI write path
	logic aw_full_q, w_full_q;
	logic [AW-1:0] aw_addr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
	wire aw_full_d = (aw_full_q || aw_take) && !do_wr;
	wire w_full_d = (w_full_q || w_take) && !do_wr;
	wire wa_ctrl = do_wr && aw_addr_q == OFS_CTRL;
	wire wa_clr = do_wr && aw_addr_q == OFS_IRQ_CLR;
	wire wa_en = do_wr && aw_addr_q == OFS_IRQ_EN;
	wire wa_cidx = do_wr && aw_addr_q == OFS_CASE_IDX;
	wire wa_cdat = do_wr && aw_addr_q == OFS_CASE_DATA;
	wire wa_warn = do_wr && aw_addr_q == OFS_WARN_MASK;
	wire wa_cont = do_wr && aw_addr_q == OFS_CONT_MASK;
	wire wa_sidx = do_wr && aw_addr_q == OFS_SUGG_IDX;
	wire wa_scfg = do_wr && aw_addr_q == OFS_SUGG_CFG;
	wire wr_mapped = aw_addr_q == OFS_STATUS || aw_addr_q == OFS_ACTIVE
		|| aw_addr_q == OFS_SUGG_DATA || wa_ctrl || wa_clr || wa_en || wa_cidx
		|| wa_cdat || wa_warn || wa_cont || wa_sidx || wa_scfg;

	wire [31:0] v_ctrl = merge({23'h0, ctrl_q}, wdata_q, wstrb_q);
	wire [31:0] v_cdat = merge({11'h0, case_tab_q[case_idx_q]}, wdata_q, wstrb_q);
	wire [31:0] v_warn = merge({16'h0, warn_mask_q}, wdata_q, wstrb_q);
	wire [31:0] v_cont = merge({16'h0, cont_mask_q}, wdata_q, wstrb_q);
	wire [31:0] v_scfg = merge({4'h0, sugg_tol_q, 4'h0, sugg_max_q}, wdata_q, wstrb_q);
	wire [31:0] v_misc = merge(32'h0000_0000, wdata_q, wstrb_q);
	// Rejected writes leave the register unchanged and flag a config error
	wire rej_ctrl = v_ctrl[CTRL_CONT] && v_ctrl[CTRL_WF2]; // [RULE_08]
	wire rej_cdat = {1'b0, v_cdat[REC_FS +: 4]} >= FS_COUNT[var_sel]; // [RULE_12]
	wire rej_warn = |(v_warn[SEC_N-1:0] & cont_mask_q); // [RULE_09]
	wire rej_cont = |(v_cont[SEC_N-1:0] & warn_mask_q); // [RULE_09]
	wire ev_cfg = (wa_ctrl && rej_ctrl) || (wa_cdat && rej_cdat)
		|| (wa_warn && rej_warn) || (wa_cont && rej_cont);
	wire sugg_clear = wa_ctrl && !rej_ctrl && v_ctrl[CTRL_SCLR];

	// Sticky status; a new event beats a clear in the same cycle
	wire [ST_W-1:0] events = {ev_cfg, run && cont_en && contour_lost,
		run && field_hit, run && !sel_ok};
	wire [ST_W-1:0] clr_bits = wa_clr ? v_misc[ST_W-1:0] : '0;
	wire [ST_W-1:0] status_d = (status_q & ~clr_bits) | events;

	// AXI read path
	logic [RANGE_W-1:0] sugg_range;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire rd_mapped = s_axi_araddr == OFS_CTRL || s_axi_araddr == OFS_STATUS
		|| s_axi_araddr == OFS_IRQ_CLR || s_axi_araddr == OFS_IRQ_EN
		|| s_axi_araddr == OFS_CASE_IDX || s_axi_araddr == OFS_CASE_DATA
		|| s_axi_araddr == OFS_WARN_MASK || s_axi_araddr == OFS_CONT_MASK
		|| s_axi_araddr == OFS_ACTIVE || s_axi_araddr == OFS_SUGG_IDX
		|| s_axi_araddr == OFS_SUGG_DATA || s_axi_araddr == OFS_SUGG_CFG;
	wire [31:0] rd_val =
		(s_axi_araddr == OFS_CTRL) ? {23'h0, ctrl_q} :
		(s_axi_araddr == OFS_STATUS) ? {28'h0, status_q} :
		(s_axi_araddr == OFS_IRQ_EN) ? {28'h0, irq_en_q} :
		(s_axi_araddr == OFS_CASE_IDX) ? {27'h0, case_idx_q} :
		(s_axi_araddr == OFS_CASE_DATA) ? {11'h0, case_tab_q[case_idx_q]} :
		(s_axi_araddr == OFS_WARN_MASK) ? {16'h0, warn_mask_q} :
		(s_axi_araddr == OFS_CONT_MASK) ? {16'h0, cont_mask_q} :
		(s_axi_araddr == OFS_ACTIVE) ? {24'h0, have_case_q, case_undefined,
			safety_switching_output, active_case} :
		(s_axi_araddr == OFS_SUGG_IDX) ? {28'h0, sugg_idx_q} :
		(s_axi_araddr == OFS_SUGG_DATA) ? {20'h0, sugg_range} :
		(s_axi_araddr == OFS_SUGG_CFG) ? {4'h0, sugg_tol_q, 4'h0, sugg_max_q} : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			s_axi_awready <= !aw_full_d;
			s_axi_wready <= !w_full_d;
			if (aw_take) begin
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	// Configuration registers; clear bit of control never stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
			irq_en_q <= '0;
			case_idx_q <= '0;
			warn_mask_q <= '0;
			cont_mask_q <= '0;
			sugg_idx_q <= '0;
			sugg_max_q <= SUGG_MAX_RST;
			sugg_tol_q <= SUGG_TOL_RST;
		end else begin
			if (wa_ctrl && !rej_ctrl) begin
				ctrl_q <= v_ctrl[CTRL_W-1:0]; // [RULE_08]
			end
			if (wa_en) begin
				irq_en_q <= v_misc[ST_W-1:0];
			end
			if (wa_cidx) begin
				case_idx_q <= v_misc[CASE_W-1:0];
			end
			if (wa_warn && !rej_warn) begin
				warn_mask_q <= v_warn[SEC_N-1:0]; // [RULE_09]
			end
			if (wa_cont && !rej_cont) begin
				cont_mask_q <= v_cont[SEC_N-1:0];
			end
			if (wa_sidx) begin
				sugg_idx_q <= v_misc[SEC_W-1:0];
			end
			if (wa_scfg) begin
				sugg_max_q <= v_scfg[RANGE_W-1:0];
				sugg_tol_q <= v_scfg[SCFG_TOL +: RANGE_W];
			end
		end
	end

	// Case records, written through the index register [RULE_10]
	for (genvar i = 0; i < NUM_CASES; i++) begin : g_case
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				case_tab_q[i] <= '0;
			end else if (wa_cdat && !rej_cdat && case_idx_q == CASE_W'(i)) begin
				case_tab_q[i] <= v_cdat[REC_W-1:0]; // [RULE_12]
			end
		end
	end

	// Last good case is kept while the input is undefined
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_case <= '0;
			have_case_q <= 1'b0;
			case_undefined <= 1'b1;
			safety_switching_output <= 1'b0;
			status_q <= '0;
			irq <= 1'b0;
		end else begin
			if (sel_ok) begin
				active_case <= cand; // [RULE_01]
				have_case_q <= 1'b1;
			end
			case_undefined <= !sel_ok; // [RULE_17]
			safety_switching_output <= out_on_d; // [RULE_06]
			status_q <= status_d;
			irq <= |(status_d & irq_en_q);
		end
	end

	field_suggest u_suggest (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(sugg_clear),
		.enable(ctrl_q[CTRL_SUGG]),
		.meas_valid(meas_valid),
		.meas_angle(meas_angle),
		.meas_range(meas_range),
		.max_range(sugg_max_q),
		.tol(sugg_tol_q),
		.rd_idx(sugg_idx_q),
		.rd_range(sugg_range)
	); // [RULE_13] [RULE_14]
endmodule
`default_nettype wire

// file: tb/case_sel_assertions.sv
/*
 Concurrent checks on the case selector ports, bound into the design.
 Assumes one aclk domain with a synchronous active-low aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module case_sel_checker (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic s_axi_rvalid, // R valid
	input wire logic field_hit, // Intrusion
	input wire logic safety_switching_output, // Output ON
	input wire logic case_undefined, // No case
	input wire logic [case_sel_pkg::CASE_W-1:0] active_case // Case index
);
	import case_sel_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rst;
		$rose(aresetn) |-> !safety_switching_output && case_undefined && active_case == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("Outputs not in reset state");
	property p_hit_off;
		field_hit |=> !safety_switching_output;
	endproperty
	a_hit_off: assert property (p_hit_off) else $error("Output on during intrusion");
	property p_undef_off;
		case_undefined |-> !safety_switching_output;
	endproperty
	a_undef_off: assert property (p_undef_off) else $error("Output on while undefined");
	property p_on_cause;
		safety_switching_output |-> !$past(field_hit) && !case_undefined;
	endproperty
	a_on_cause: assert property (p_on_cause) else $error("Output on without cause");
	property p_hold;
		case_undefined && $past(case_undefined) |-> $stable(active_case);
	endproperty
	a_hold: assert property (p_hold) else $error("Case moved while undefined");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("Read answer late");
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("Write answer late");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("Read taken while busy");
endmodule
bind case_selector case_sel_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .field_hit, .safety_switching_output, .case_undefined, .active_case);
`default_nettype wire

// file: tb/pair_ctrl_model.sv
/*
 External controller model presenting static control pairs.
 Assumes the bench sets the case index and the pairs to break.
*/
`timescale 1ns/1ps
`default_nettype none
module pair_ctrl_model #(
	parameter int W = 3
) (
	input wire logic aclk, // Clock
	input wire logic [W-1:0] sel, // Case index
	input wire logic [W-1:0] bad, // Pairs to break
	output logic [W-1:0] pair_p, // Line 1
	output logic [W-1:0] pair_n // Line 2
);
	// Switch at one edge so the new case is active long before it is used
	always_ff @(posedge aclk) begin
		pair_p <= sel;
		pair_n <= ~sel ^ bad;
	end
endmodule
`default_nettype wire

// file: tb/tb.sv
/*
 Self-checking bench for the case selector: AXI4-Lite setup, a table of
 pair patterns, then speed, contour, intrusion, config and suggest tests.
 Assumes the pair controller model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	import case_sel_pkg::*;
	typedef struct packed {
		logic link;
		logic [4:0] idx;
		logic [4:0] bad;
		logic undef;
		logic [4:0] exp;
	} row_t;
	localparam row_t ROWS [0:7] = '{
		{1'b0, 5'h00, 5'h00, 1'b0, 5'h00},
		{1'b0, 5'h05, 5'h00, 1'b0, 5'h05},
		{1'b0, 5'h07, 5'h00, 1'b0, 5'h07},
		{1'b0, 5'h03, 5'h02, 1'b1, 5'h07},
		{1'b0, 5'h02, 5'h00, 1'b0, 5'h02},
		{1'b1, 5'h10, 5'h00, 1'b0, 5'h10},
		{1'b1, 5'h1F, 5'h00, 1'b0, 5'h1F},
		{1'b1, 5'h08, 5'h00, 1'b1, 5'h1F}
	};
	localparam logic [4:0] RECS [0:5] = '{5'h00, 5'h02, 5'h05, 5'h07, 5'h10, 5'h1F};
	logic aclk = '0;
	logic aresetn = '0;
	addr_t s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [LOCAL_PAIRS-1:0] local_pair_p, local_pair_n;
	logic [LINK_PAIRS-1:0] link_pair_p, link_pair_n;
	logic field_hit = '0, contour_lost = '0, speed_valid = '0, meas_valid = '0;
	logic [CASE_W-1:0] speed_case = '0, active_case;
	logic [SEC_W-1:0] meas_angle = '0;
	logic [RANGE_W-1:0] meas_range = '0;
	logic safety_switching_output, case_undefined, irq;
	logic [4:0] sel = '0, bad = '0;
	int n_errors = 0, checked = 0;

	always #12.5 aclk = ~aclk;

	case_selector i_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .local_pair_p, .local_pair_n,
		.link_pair_p, .link_pair_n, .field_hit, .contour_lost, .speed_case, .speed_valid,
		.meas_valid, .meas_angle, .meas_range, .safety_switching_output, .active_case,
		.case_undefined, .irq
	);
	pair_ctrl_model #(.W(LOCAL_PAIRS)) i_loc (.aclk, .sel(sel[2:0]), .bad(bad[2:0]),
		.pair_p(local_pair_p), .pair_n(local_pair_n));
	pair_ctrl_model #(.W(LINK_PAIRS)) i_lnk (.aclk, .sel, .bad, .pair_p(link_pair_p),
		.pair_n(link_pair_n));

	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input addr_t a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= '0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= '0;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= '0;
	endtask
	task automatic rd(input addr_t a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= '0;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= '0;
	endtask
	task automatic rc(input addr_t a, input logic [31:0] e);
		rd(a);
		ck(d, e);
	endtask
	task automatic smp(input logic [3:0] a, input logic [11:0] v);
		@(posedge aclk);
		meas_valid <= 1'b1;
		meas_angle <= a;
		meas_range <= v;
		@(posedge aclk);
		meas_valid <= '0;
	endtask
	task automatic sg(input logic [31:0] i, input logic [31:0] e);
		wr(OFS_SUGG_IDX, i);
		rc(OFS_SUGG_DATA, e);
	endtask
	task automatic end_of_test;
		$display("Checks: %0d, errors: %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		end_of_test;
	end

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		ck(safety_switching_output, '0);
		ck(case_undefined, 32'h1);
		ck(irq, '0);
		rc(OFS_CTRL, '0);
		wr(OFS_CTRL, 32'h82);
		foreach (RECS[i]) begin
			wr(OFS_CASE_IDX, {27'h0, RECS[i]});
			wr(OFS_CASE_DATA, {11'h0, 5'h13, 13'h0, RECS[i][2:0]});
		end
		foreach (ROWS[i]) begin
			wr(OFS_CTRL, 32'h82 | {29'h0, ROWS[i].link, 2'h0});
			sel <= ROWS[i].idx;
			bad <= ROWS[i].bad;
			repeat (6) @(posedge aclk);
			ck(active_case, ROWS[i].exp);
			ck(case_undefined, ROWS[i].undef);
			ck(safety_switching_output, !ROWS[i].undef);
		end
		sel <= 5'h02;
		bad <= '0;
		speed_case <= 5'h05;
		speed_valid <= 1'b1;
		wr(OFS_CTRL, 32'h8A);
		repeat (4) @(posedge aclk);
		ck(active_case, 32'h5);
		speed_valid <= '0;
		repeat (4) @(posedge aclk);
		ck(case_undefined, 32'h1);
		speed_valid <= 1'b1;
		wr(OFS_CTRL, 32'h92);
		repeat (4) @(posedge aclk);
		ck(case_undefined, 32'h1);
		speed_case <= 5'h02;
		repeat (4) @(posedge aclk);
		ck(active_case, 32'h2);
		ck(safety_switching_output, 32'h1);
		wr(OFS_CTRL, 32'hA2);
		contour_lost <= 1'b1;
		repeat (3) @(posedge aclk);
		ck(safety_switching_output, '0);
		contour_lost <= '0;
		repeat (3) @(posedge aclk);
		ck(safety_switching_output, 32'h1);
		wr(OFS_IRQ_CLR, 32'hF);
		wr(OFS_IRQ_EN, 32'h2);
		field_hit <= 1'b1;
		repeat (3) @(posedge aclk);
		ck(safety_switching_output, '0);
		ck(irq, 32'h1);
		field_hit <= '0;
		rd(OFS_STATUS);
		ck(d & 32'h2, 32'h2);
		wr(OFS_IRQ_CLR, 32'h2);
		repeat (2) @(posedge aclk);
		ck(irq, '0);
		wr(OFS_IRQ_EN, '0);
		field_hit <= 1'b1;
		repeat (3) @(posedge aclk);
		ck(irq, '0);
		field_hit <= '0;
		wr(OFS_CTRL, 32'hE2);
		rc(OFS_CTRL, 32'hA2);
		rd(OFS_STATUS);
		ck(d & 32'h8, 32'h8);
		wr(OFS_WARN_MASK, 32'hF0);
		wr(OFS_CONT_MASK, 32'h180);
		rc(OFS_CONT_MASK, '0);
		wr(OFS_CONT_MASK, 32'h300);
		rc(OFS_CONT_MASK, 32'h300);
		wr(OFS_CASE_IDX, 32'h5);
		wr(OFS_CASE_DATA, 32'h130008);
		rc(OFS_CASE_DATA, 32'h130005);
		rd(8'hF0);
		ck(r, RESP_SLVERR);
		ck(d, '0);
		wr(8'hF0, 32'h1);
		ck(r, RESP_SLVERR);
		wr(OFS_SUGG_CFG, 32'h100800);
		wr(OFS_CTRL, 32'h182);
		smp(4'h2, 12'h300);
		smp(4'h2, 12'h200);
		smp(4'h3, 12'h900);
		sg(32'h2, 32'h1F0);
		sg(32'h3, 32'h800);
		sg(32'h4, 32'h800);
		wr(OFS_CTRL, 32'h382);
		sg(32'h2, 32'h800);
		wr(OFS_CASE_IDX, 32'h2);
		wr(OFS_CASE_DATA, 32'h1301D2);
		sel <= 5'h05;
		repeat (6) @(posedge aclk);
		ck(case_undefined, 32'h1);
		ck(active_case, 32'h2);
		sel <= 5'h07;
		repeat (6) @(posedge aclk);
		ck(active_case, 32'h7);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		ck(safety_switching_output, '0);
		ck(case_undefined, 32'h1);
		rc(OFS_CTRL, '0);
		end_of_test;
	end
endmodule
`default_nettype wire
